// ### rtl/grs_map.vh
`ifndef GRS_MAP_VH
`define GRS_MAP_VH

// Status byte bit positions
`define GRS_SB_SWEEP 0
`define GRS_SB_HWERR 1
`define GRS_SB_EXERR 2
`define GRS_SB_LOCAL 3
`define GRS_SB_READY 4
`define GRS_SB_ERSUM 5
`define GRS_SB_RQS 6
`define GRS_SB_PCHG 7

// Request mask reset value and the bits that may raise a request
`define GRS_MASK_RST 8'h00
`define GRS_MASK_USED 8'hBF

// Message characters, upper case
`define GRS_CH_C 8'h43
`define GRS_CH_H 8'h48
`define GRS_CH_I 8'h49
`define GRS_CH_M 8'h4D
`define GRS_CH_P 8'h50
`define GRS_CH_R 8'h52
`define GRS_CH_S 8'h53
`define GRS_CH_Z 8'h5A
`define GRS_CH_0 8'h30
`define GRS_CH_9 8'h39
`define GRS_CH_LF 8'h0A
`define GRS_CH_SP 8'h20
`define GRS_CASE_FOLD 8'hDF

// Largest mask value
`define GRS_MASK_MAX 9'h0FF

`endif

// ### rtl/grs_sync.v
`timescale 1ns/100ps
`include "grs_map.vh"

module grs_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Asynchronous inputs and their filtered copies
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg out_q;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // A change counts only once two settled stages agree
          if (s2_q == s3_q) begin
            out_q <= s3_q;
          end
        end
      end
      assign q[i] = out_q;
    end
  endgenerate

endmodule

// ### rtl/grs_remote.v
`timescale 1ns/100ps
`include "grs_map.vh"

module grs_remote (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Bus conditions
  input wire ren,
  input wire my_listen,
  input wire gtl,
  input wire llo,
  // Front panel
  input wire key_press,
  // State
  output reg remote_q,
  output reg lockout_q,
  output reg went_remote_q
);

  localparam ST_LOCAL = 1'b0;
  localparam ST_REMOTE = 1'b1;

  reg remote_d;
  reg lockout_d;

  always @* begin
    remote_d = remote_q;
    lockout_d = lockout_q;
    if (!ren) begin
      remote_d = ST_LOCAL;
      lockout_d = 1'b0;
    end else begin
      if (llo) begin
        lockout_d = 1'b1;
      end
      case (remote_q)
        ST_LOCAL: begin
          if (my_listen) begin
            remote_d = ST_REMOTE;
          end
        end
        ST_REMOTE: begin
          if (gtl) begin
            remote_d = ST_LOCAL;
          end else if (key_press && !lockout_q && !llo) begin
            // Key is dead once lockout is seen, even in the same cycle
            remote_d = ST_LOCAL;
          end
        end
        default: begin
          remote_d = ST_LOCAL;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_q <= ST_LOCAL;
      lockout_q <= 1'b0;
      went_remote_q <= 1'b0;
    end else begin
      remote_q <= remote_d;
      lockout_q <= lockout_d;
      went_remote_q <= (remote_d == ST_REMOTE) && (remote_q == ST_LOCAL);
    end
  end

endmodule

// ### rtl/grs_top.v
`timescale 1ns/100ps
`include "grs_map.vh"

module grs_top (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Bus control lines
  input wire ren_pin,
  output reg srq_o,
  output reg srq_oe,
  // Decoded bus commands, one-cycle pulses on sys_clk
  input wire bus_dcl,
  input wire bus_sdc,
  input wire bus_gtl,
  input wire bus_llo,
  input wire bus_my_listen,
  input wire bus_my_talk,
  input wire bus_spe,
  input wire bus_spd,
  // Received message bytes
  input wire msg_valid,
  input wire [7:0] msg_data,
  // Front panel
  input wire local_key_pin,
  // Instrument status events
  input wire sweep_done,
  input wire sweep_restart,
  input wire hw_err_set,
  input wire hw_err_read,
  input wire hw_fault,
  input wire exec_err_read,
  input wire param_chg_set,
  input wire param_chg_read,
  input wire inst_ready,
  // Serial poll answer
  output reg poll_valid,
  output reg [7:0] poll_byte,
  // Mode and action outputs
  output wire remote_mode,
  output wire lockout_active,
  output reg entry_open,
  output reg full_preset,
  output reg partial_preset
);

  localparam PS_IDLE = 3'h0;
  localparam PS_R = 3'h1;
  localparam PS_NUM = 3'h2;
  localparam PS_NUM_H = 3'h3;
  localparam PS_I = 3'h4;
  localparam PS_P = 3'h5;
  localparam PS_C = 3'h6;
  localparam PS_OTHER = 3'h7;

  // Reset release
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_sync_n;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sync_n = rst_s2_q;

  // Pin inputs
  wire [1:0] pins_sync;
  wire ren;
  wire key_lvl;

  grs_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .d({local_key_pin, ren_pin}),
    .q(pins_sync)
  );
  assign ren = pins_sync[0];
  assign key_lvl = pins_sync[1];

  reg key_prev_q;
  wire key_press;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      key_prev_q <= 1'b0;
    end else begin
      key_prev_q <= key_lvl;
    end
  end
  assign key_press = key_lvl && !key_prev_q;

  // Remote and lockout state
  wire went_remote;

  grs_remote u_remote (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .ren(ren),
    .my_listen(bus_my_listen),
    .gtl(bus_gtl),
    .llo(bus_llo),
    .key_press(key_press),
    .remote_q(remote_mode),
    .lockout_q(lockout_active),
    .went_remote_q(went_remote)
  );

  // Selected clear is expected already qualified by our address
  wire dev_clear;
  assign dev_clear = bus_dcl || bus_sdc;

  // Message parser
  reg [2:0] ps_q;
  reg [2:0] ps_d;
  reg [8:0] val_q;
  reg [8:0] val_d;
  reg over_q;
  reg over_d;
  reg mask_load;
  reg exec_set;
  reg cs_cmd;
  reg fp_cmd;
  reg pp_cmd;
  wire [7:0] ch;
  wire is_digit;
  wire [11:0] val_x10;
  wire [11:0] val_sum;

  // Letters folded to upper case; digits are tested on the raw byte, as the fold clears their bit 5
  assign ch = msg_data & `GRS_CASE_FOLD;
  assign is_digit = (msg_data >= `GRS_CH_0) && (msg_data <= `GRS_CH_9);
  assign val_x10 = {3'h0, val_q} * 12'h00A;
  assign val_sum = val_x10 + {4'h0, msg_data - `GRS_CH_0};

  always @* begin
    ps_d = ps_q;
    val_d = val_q;
    over_d = over_q;
    mask_load = 1'b0;
    exec_set = 1'b0;
    cs_cmd = 1'b0;
    fp_cmd = 1'b0;
    pp_cmd = 1'b0;
    if (dev_clear || went_remote) begin
      ps_d = PS_IDLE;
      val_d = 9'h000;
      over_d = 1'b0;
    end else if (msg_valid) begin
      case (ps_q)
        PS_IDLE: begin
          if (msg_data == `GRS_CH_SP || msg_data == `GRS_CH_LF) begin
            ps_d = PS_IDLE;
          end else if (ch == `GRS_CH_R) begin
            ps_d = PS_R;
          end else if (ch == `GRS_CH_I) begin
            ps_d = PS_I;
          end else if (ch == `GRS_CH_P) begin
            ps_d = PS_P;
          end else if (ch == `GRS_CH_C) begin
            ps_d = PS_C;
          end else begin
            ps_d = PS_OTHER;
          end
        end
        PS_R: begin
          if (ch == `GRS_CH_M) begin
            ps_d = PS_NUM;
            val_d = 9'h000;
            over_d = 1'b0;
          end else begin
            ps_d = PS_OTHER;
          end
        end
        PS_NUM: begin
          if (is_digit) begin
            if (val_sum > {3'h0, `GRS_MASK_MAX}) begin
              over_d = 1'b1;
            end else begin
              val_d = val_sum[8:0];
            end
          end else if (ch == `GRS_CH_H) begin
            ps_d = PS_NUM_H;
          end else if (msg_data != `GRS_CH_SP) begin
            exec_set = 1'b1;
            ps_d = PS_IDLE;
          end
        end
        PS_NUM_H: begin
          ps_d = PS_IDLE;
          if (ch == `GRS_CH_Z && !over_q) begin
            mask_load = 1'b1;
          end else begin
            exec_set = 1'b1;
          end
        end
        PS_I: begin
          ps_d = PS_IDLE;
          fp_cmd = (ch == `GRS_CH_P);
          exec_set = (ch != `GRS_CH_P);
        end
        PS_P: begin
          ps_d = PS_IDLE;
          pp_cmd = (ch == `GRS_CH_P);
          exec_set = (ch != `GRS_CH_P);
        end
        PS_C: begin
          ps_d = PS_IDLE;
          cs_cmd = (ch == `GRS_CH_S);
          exec_set = (ch != `GRS_CH_S);
        end
        PS_OTHER: begin
          // Entries for other functions end on a terminator or line end
          if (ch == `GRS_CH_Z || msg_data == `GRS_CH_LF) begin
            ps_d = PS_IDLE;
          end
        end
        default: begin
          ps_d = PS_IDLE;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ps_q <= PS_IDLE;
      val_q <= 9'h000;
      over_q <= 1'b0;
    end else begin
      ps_q <= ps_d;
      val_q <= val_d;
      over_q <= over_d;
    end
  end

  // Request mask
  reg [7:0] mask_q;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_q <= `GRS_MASK_RST;
    end else if (fp_cmd) begin
      mask_q <= `GRS_MASK_RST;
    end else if (mask_load) begin
      mask_q <= val_q[7:0];
    end
  end

  // Sticky status bits; a set in the same cycle as a clear wins
  wire stat_clear;
  reg sweep_q;
  reg hwerr_q;
  reg exerr_q;
  reg pchg_q;

  assign stat_clear = cs_cmd || fp_cmd || dev_clear;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sweep_q <= 1'b0;
      hwerr_q <= 1'b0;
      exerr_q <= 1'b0;
      pchg_q <= 1'b0;
    end else begin
      // Updated in local and remote alike
      sweep_q <= sweep_done || (sweep_q && !(sweep_restart || stat_clear));
      // An unresolved hardware fault survives a status clear
      hwerr_q <= hw_err_set || hw_fault ||
                 (hwerr_q && !(hw_err_read || stat_clear));
      exerr_q <= exec_set || (exerr_q && !(exec_err_read || stat_clear));
      pchg_q <= param_chg_set || (pchg_q && !(param_chg_read || stat_clear));
    end
  end

  // Assembled status byte; bits 3 and 4 are live, not latched
  wire [7:0] sb_raw;
  wire rqs;
  wire [7:0] status_byte;

  assign sb_raw[`GRS_SB_SWEEP] = sweep_q;
  assign sb_raw[`GRS_SB_HWERR] = hwerr_q;
  assign sb_raw[`GRS_SB_EXERR] = exerr_q;
  assign sb_raw[`GRS_SB_LOCAL] = !remote_mode;
  assign sb_raw[`GRS_SB_READY] = inst_ready;
  assign sb_raw[`GRS_SB_ERSUM] = hwerr_q || exerr_q;
  assign sb_raw[`GRS_SB_RQS] = 1'b0;
  assign sb_raw[`GRS_SB_PCHG] = pchg_q;

  // Mask bit 6 is dropped here, so whatever was written there is moot
  assign rqs = |(sb_raw & mask_q & `GRS_MASK_USED);

  assign status_byte = {sb_raw[7], rqs, sb_raw[5:0]};

  // Serial poll; reading the byte changes no status bit
  reg spe_q;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      spe_q <= 1'b0;
      poll_valid <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      if (bus_spd || dev_clear) begin
        spe_q <= 1'b0;
      end else if (bus_spe) begin
        spe_q <= 1'b1;
      end
      poll_valid <= spe_q && bus_my_talk;
      if (spe_q && bus_my_talk) begin
        poll_byte <= status_byte;
      end
    end
  end

  // SRQ line and action strobes
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      srq_o <= 1'b0;
      srq_oe <= 1'b0;
      entry_open <= 1'b0;
      full_preset <= 1'b0;
      partial_preset <= 1'b0;
    end else begin
      srq_o <= 1'b0;
      // Open drain: pulling low is the true state of the line
      srq_oe <= rqs;
      entry_open <= (ps_d != PS_IDLE);
      // Device clear never reaches the settings
      full_preset <= fp_cmd;
      partial_preset <= pp_cmd;
    end
  end

endmodule

// ### tb/grs_chk.sv
`timescale 1ns/100ps
module grs_chk (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Watched ports
  input wire ren_pin,
  input wire srq_o,
  input wire srq_oe,
  input wire bus_dcl,
  input wire bus_gtl,
  input wire bus_llo,
  input wire bus_my_listen,
  input wire bus_my_talk,
  input wire msg_valid,
  input wire poll_valid,
  input wire [7:0] poll_byte,
  input wire remote_mode,
  input wire lockout_active,
  input wire entry_open,
  input wire full_preset
);
  // Cycles with REN steady, long enough to pass the pin filter
  reg [2:0] hi_q;
  reg [2:0] lo_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= 3'h0;
      lo_q <= 3'h0;
    end else begin
      hi_q <= !ren_pin ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
      lo_q <= ren_pin ? 3'h0 : (lo_q == 3'h7 ? lo_q : lo_q + 3'h1);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_srq_open_drain: assert property (srq_o == 1'b0)
    else $error("srq pin driven high");
  a_srq_is_rqs: assert property (poll_valid |-> poll_byte[6] == srq_oe)
    else $error("rqs bit and srq differ");
  a_poll_by_talk: assert property (poll_valid |-> $past(bus_my_talk))
    else $error("status byte sent without talk address");
  a_error_summary: assert property (poll_valid |-> poll_byte[5] == |poll_byte[2:1])
    else $error("error summary wrong");
  a_listen_remote: assert property ($rose(remote_mode) |-> $past(bus_my_listen))
    else $error("remote without listen address");
  a_gtl_local: assert property (bus_gtl |=> !remote_mode)
    else $error("go to local ignored");
  a_ren_off_local: assert property (lo_q == 3'h7 |-> !remote_mode && !lockout_active)
    else $error("ren false did not force local");
  a_llo_locks: assert property (bus_llo && hi_q == 3'h7 |=> lockout_active)
    else $error("lockout not set");
  a_lock_holds: assert property (remote_mode && lockout_active && !bus_gtl && hi_q == 3'h7
    |=> remote_mode)
    else $error("left remote under lockout");
  a_clear_entry: assert property (bus_dcl && !msg_valid |=> !entry_open)
    else $error("device clear kept entry");
  a_preset_srq: assert property (full_preset |-> ##[1:3] !srq_oe)
    else $error("srq after full preset");
endmodule
bind grs_top grs_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ren_pin(ren_pin),
  .srq_o(srq_o), .srq_oe(srq_oe), .bus_dcl(bus_dcl), .bus_gtl(bus_gtl), .bus_llo(bus_llo),
  .bus_my_listen(bus_my_listen), .bus_my_talk(bus_my_talk), .msg_valid(msg_valid),
  .poll_valid(poll_valid), .poll_byte(poll_byte), .remote_mode(remote_mode),
  .lockout_active(lockout_active), .entry_open(entry_open), .full_preset(full_preset));

// ### tb/grs_ctl.sv
`timescale 1ns/100ps
module grs_ctl (
  // Clock
  input wire sys_clk,
  // Bus lines and decoded commands
  output reg ren,
  output reg [7:0] cmd,
  output reg msg_valid,
  output reg [7:0] msg_data
);
  integer j;
  initial begin
    ren = 1'b0;
    cmd = 8'h00;
    msg_valid = 1'b0;
    msg_data = 8'h00;
  end
  // Bits: 0 dcl, 1 sdc, 2 gtl, 3 llo, 4 listen, 5 talk, 6 spe, 7 spd
  task pulse(input integer k);
    begin
      @(negedge sys_clk);
      cmd = 8'h01 << k;
      @(negedge sys_clk);
      cmd = 8'h00;
    end
  endtask
  // REN settles past the pin filter before any address follows
  task set_ren(input v);
    begin
      @(negedge sys_clk);
      ren = v;
      repeat (6) @(negedge sys_clk);
    end
  endtask
  // Released data lines show the inverse of the last byte
  task send(input string s);
    begin
      for (j = 0; j < s.len(); j++) begin
        @(negedge sys_clk);
        msg_valid = 1'b1;
        msg_data = s[j];
      end
      @(negedge sys_clk);
      msg_valid = 1'b0;
      msg_data = ~msg_data;
    end
  endtask
  task poll;
    begin
      pulse(6);
      pulse(5);
      pulse(7);
    end
  endtask
endmodule

// ### tb/tb_gpib_remote_status_srq.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_gpib_remote_status_srq;
  reg sys_clk;
  reg rst_n;
  reg local_key_pin;
  reg hw_fault;
  reg inst_ready;
  reg [6:0] ev;
  reg [7:0] st;
  reg [7:0] mask;
  reg [7:0] m;
  reg [7:0] exp_b;
  reg [7:0] masks [0:3];
  reg [7:0] q[$];
  reg rem;
  reg [31:0] r;
  wire ren, msg_valid, srq_o, srq_oe, poll_valid, remote_mode, lockout_active;
  wire entry_open, full_preset, partial_preset;
  wire [7:0] cmd;
  wire [7:0] msg_data;
  wire [7:0] poll_byte;
  integer n_errors = 0;
  integer tests_run = 0;
  integer seed = 7218;
  integer n_fp = 0;
  integer n_pp = 0;
  integer i;
  integer k;
  // Expected status byte from the bench's own model
  wire [7:0] xb0 = {st[7], 1'b0, st[1] | st[2], inst_ready, !rem, st[2:0]};
  wire [7:0] xb = xb0 | {1'b0, |(xb0 & mask & 8'hbf), 6'h00};
  grs_ctl ctl (.sys_clk(sys_clk), .ren(ren), .cmd(cmd), .msg_valid(msg_valid),
    .msg_data(msg_data));
  grs_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .ren_pin(ren), .srq_o(srq_o),
    .srq_oe(srq_oe), .bus_dcl(cmd[0]), .bus_sdc(cmd[1]), .bus_gtl(cmd[2]), .bus_llo(cmd[3]),
    .bus_my_listen(cmd[4]), .bus_my_talk(cmd[5]), .bus_spe(cmd[6]), .bus_spd(cmd[7]),
    .msg_valid(msg_valid), .msg_data(msg_data), .local_key_pin(local_key_pin),
    .sweep_done(ev[0]), .sweep_restart(ev[1]), .hw_err_set(ev[2]), .hw_err_read(ev[3]),
    .hw_fault(hw_fault), .exec_err_read(ev[4]), .param_chg_set(ev[5]),
    .param_chg_read(ev[6]), .inst_ready(inst_ready), .poll_valid(poll_valid),
    .poll_byte(poll_byte), .remote_mode(remote_mode), .lockout_active(lockout_active),
    .entry_open(entry_open), .full_preset(full_preset), .partial_preset(partial_preset));
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Ready is a live bit, so it is varied before each poll and the note waits for the model
  task poll;
    begin
      r = $random(seed);
      inst_ready = r[0];
      cyc(1);
      q.push_back(xb);
      ctl.poll;
    end
  endtask
  task evp(input integer e, input integer b, input v);
    begin
      @(negedge sys_clk);
      ev = 7'h01 << e;
      @(negedge sys_clk);
      ev = 7'h00;
      if (v || b != 1 || !hw_fault) st[b] = v;
      cyc(2);
    end
  endtask
  // Letters go out in random case
  task msg(input string s);
    begin
      for (i = 0; i < s.len(); i++)
        if ($random(seed) & 1) s[i] = s[i] | 8'h20;
      ctl.send(s);
      cyc(4);
    end
  endtask
  task key;
    begin
      @(negedge sys_clk);
      local_key_pin = 1'b1;
      cyc(6);
      local_key_pin = 1'b0;
      cyc(6);
    end
  endtask
  task tend(input string n);
    $display("test %s done", n);
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  always @(negedge sys_clk) begin
    if (full_preset === 1'b1) n_fp++;
    if (partial_preset === 1'b1) n_pp++;
    if (poll_valid === 1'b1) begin
      exp_b = q.size() ? q.pop_front() : 8'h00;
      `CHK("status byte", exp_b, poll_byte)
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #300000;
    n_errors++;
    results;
  end
  initial begin
    rst_n = 1'b0;
    local_key_pin = 1'b0;
    hw_fault = 1'b0;
    inst_ready = 1'b1;
    ev = 7'h00;
    st = 8'h00;
    mask = 8'h00;
    rem = 1'b0;
    masks = '{8'h83, 8'h40, 8'hff, 8'h00};
    cyc(12);
    rst_n = 1'b1;
    cyc(6);
    `CHK("remote", 1'b0, remote_mode)
    `CHK("lockout", 1'b0, lockout_active)
    evp(0, 0, 1);
    poll;
    tend("power up");
    ctl.pulse(4);
    `CHK("remote", 1'b0, remote_mode)
    ctl.set_ren(1'b1);
    ctl.send("RM1");
    `CHK("entry", 1'b1, entry_open)
    ctl.pulse(4);
    rem = 1'b1;
    `CHK("remote", 1'b1, remote_mode)
    // The discard follows the registered remote transition by one cycle
    cyc(1);
    `CHK("entry", 1'b0, entry_open)
    tend("remote");
    evp(2, 1, 1);
    evp(5, 7, 1);
    for (k = 0; k < 6; k++) begin
      r = $random(seed);
      m = (k < 4) ? masks[k] : r[7:0];
      msg($sformatf("RM %0dHZ", m));
      mask = m;
      poll;
      poll;
      `CHK("srq", xb[6], srq_oe)
    end
    msg("RM300HZ");
    st[2] = 1'b1;
    poll;
    tend("mask");
    msg("RM255HZ");
    mask = 8'hff;
    for (k = 0; k < 2; k++) begin
      msg("RM999HZ");
      st[2] = 1'b1;
      evp(0, 0, 1);
      hw_fault = (k == 1);
      ctl.send("RM1");
      ctl.pulse(k);
      // An unresolved fault keeps the hardware error bit through the clear
      st = {6'h00, hw_fault, 1'b0};
      `CHK("entry", 1'b0, entry_open)
      poll;
      `CHK("srq", xb[6], srq_oe)
    end
    hw_fault = 1'b0;
    tend("clear");
    ctl.pulse(3);
    `CHK("lockout", 1'b1, lockout_active)
    key;
    `CHK("remote", 1'b1, remote_mode)
    ctl.pulse(2);
    rem = 1'b0;
    `CHK("remote", 1'b0, remote_mode)
    ctl.pulse(4);
    ctl.set_ren(1'b0);
    `CHK("remote", 1'b0, remote_mode)
    `CHK("lockout", 1'b0, lockout_active)
    ctl.set_ren(1'b1);
    ctl.pulse(4);
    key;
    `CHK("remote", 1'b0, remote_mode)
    tend("lockout");
    evp(0, 0, 1);
    evp(2, 1, 1);
    msg("RM999HZ");
    st[2] = 1'b1;
    poll;
    // Clear pulses 1, 3, 4 and 6 reset bits 0, 1, 2 and 7
    for (k = 0; k < 4; k++)
      evp(k + 1 + (k > 0) + (k > 2), k < 3 ? k : 7, 0);
    poll;
    ctl.pulse(4);
    rem = 1'b1;
    evp(5, 7, 1);
    msg("IP");
    mask = 8'h00;
    st = 8'h00;
    poll;
    msg("PP");
    `CHK("full preset", 1, n_fp)
    `CHK("partial preset", 1, n_pp)
    tend("preset");
    msg("RM255HZ");
    mask = 8'hff;
    evp(5, 7, 1);
    `CHK("srq", 1'b1, srq_oe)
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc(6);
    mask = 8'h00;
    st = 8'h00;
    rem = 1'b0;
    `CHK("remote", 1'b0, remote_mode)
    `CHK("lockout", 1'b0, lockout_active)
    evp(5, 7, 1);
    poll;
    `CHK("srq", 1'b0, srq_oe)
    tend("power up again");
    results;
  end
endmodule
